// ==== hdl/frm_fifo_ctrl.sv ====
// Dual-port 36-bit FIFO control: resets, mode capture, offsets, mark and retransmit.
// Assumes every pin is asynchronous to I_CORE_CLK and much slower than it.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
module frm_fifo_ctrl
	import frm_pkg::*;
#(
	parameter int unsigned DW = frm_pkg::DATA_W,
	parameter int unsigned AW = frm_pkg::ADDR_W
)
(
	// Core clock and reset
	input  wire logic                  I_CORE_CLK,
	input  wire logic                  I_RST_N,
	// Device resets
	input  wire logic                  I_MASTER_RESET_N,
	input  wire logic                  I_PARTIAL_RESET_N,
	// Write port
	input  wire logic                  I_WRITE_CLK,
	input  wire logic                  I_WRITE_ENABLE_N,
	input  wire logic [DW-1:0]         I_DATA_IN,
	// Read port
	input  wire logic                  I_READ_CLK,
	input  wire logic                  I_READ_ENABLE_N,
	input  wire logic                  I_READ_SELECT_N,
	input  wire logic                  I_OUTPUT_TRISTATE_N,
	input  wire logic                  I_MARK,
	input  wire logic                  I_RETRANSMIT_N,
	// Mode and serial offset programming
	input  wire logic                  I_FALLTHROUGH_SERIAL_IN,
	input  wire logic                  I_SERIAL_CLK,
	input  wire logic                  I_SERIAL_ENABLE_N,
	input  wire logic                  I_LOAD_N,
	// Static configuration
	input  wire logic                  I_OUTPUT_WIDTH_SELECT,
	input  wire logic                  I_INPUT_WIDTH_SELECT,
	input  wire logic                  I_BUS_MATCHING_SELECT,
	input  wire logic                  I_BYTE_ORDER_SELECT,
	input  wire logic                  I_RETRANSMIT_OPTION,
	input  wire logic                  I_FLAG_TIMING_SELECT,
	input  wire logic                  I_INTERSPERSED_PARITY,
	input  wire logic                  I_ASYNC_WRITE_SELECT,
	input  wire logic                  I_ASYNC_READ_SELECT,
	input  wire logic                  I_SERIAL_LOAD_SELECT,
	// Data out
	output logic [DW-1:0]              O_DATA_OUT,
	output logic                       O_DATA_OUT_OE,
	// Flags and static configuration
	output logic                       O_EMPTY_FLAG_N,
	output logic                       O_OUTPUT_READY_N,
	output logic                       O_FULL_FLAG_N,
	output logic                       O_INPUT_READY_N,
	output logic                       O_ALMOST_EMPTY_FLAG_N,
	output logic                       O_ALMOST_FULL_FLAG_N,
	output logic                       O_HALF_FULL_FLAG_N,
	output logic [frm_pkg::CFG_W-1:0]  O_STATIC_CONFIG
);
	import frm_pkg::*;

	localparam int NP = DW + 24;
	localparam int unsigned DEPTH = 1 << AW;
	localparam logic [AW:0] DEPTH_V = {1'b1, {AW{1'b0}}};
	localparam logic [AW:0] HALF_V  = {2'b01, {(AW-1){1'b0}}};

	logic [NP-1:0]      pin_raw;
	logic [NP-1:0]      s1_q;
	logic [NP-1:0]      s2_q;
	logic [NP-1:0]      s3_q;
	logic [NP-1:0]      pin_f_q;
	logic               wclk_f;
	logic               wen_n_f;
	logic [DW-1:0]      din_f;
	logic               rclk_f;
	logic               ren_n_f;
	logic               rcs_n_f;
	logic               tri_n_f;
	logic               mark_f;
	logic               rt_n_f;
	logic               fsi_f;
	logic               sclk_f;
	logic               sen_n_f;
	logic               ld_n_f;
	logic               mrs_f;
	logic               prs_f;
	logic [CFG_W-1:0]   static_f;
	logic               async_write_select_f;
	logic               async_read_select_f;
	logic               serial_f;
	logic               ptr_rst_n;
	logic               mst_rst_n;
	logic               wclk_d_q;
	logic               rclk_d_q;
	logic               sclk_d_q;
	logic               w_edge;
	logic               r_edge;
	logic               s_edge;
	logic               fwft_q;
	logic               async_wr_q;
	logic               async_rd_q;
	logic               serial_q;
	logic [CFG_W-1:0]   static_q;
	logic [DW-1:0]      mem [DEPTH];
	logic [AW:0]        wr_ptr_q;
	logic [AW:0]        rd_ptr_q;
	logic [AW:0]        mark_ptr_q;
	logic               mark_q;
	logic               rt_hold_q;
	logic               out_valid_q;
	logic [1:0]         fall_cnt_q;
	logic [AW:0]        count;
	logic [AW:0]        mark_span;
	logic               mark_block;
	logic               full_eff;
	logic               wr_do;
	logic               rt_req;
	logic               rd_do;
	logic               fw_rd;
	logic               fall_load;
	logic               rt_load;
	logic               pop;
	logic               rcs_drive_q;
	logic [AW-1:0]      ae_off_q;
	logic [AW-1:0]      af_off_q;
	logic [AW+1:0]      af_sum;

	assign pin_raw = {I_WRITE_CLK, I_WRITE_ENABLE_N, I_DATA_IN, I_READ_CLK, I_READ_ENABLE_N,
		I_READ_SELECT_N, I_OUTPUT_TRISTATE_N, I_MARK, I_RETRANSMIT_N,
		I_FALLTHROUGH_SERIAL_IN, I_SERIAL_CLK, I_SERIAL_ENABLE_N, I_LOAD_N,
		I_MASTER_RESET_N, I_PARTIAL_RESET_N, I_OUTPUT_WIDTH_SELECT, I_INPUT_WIDTH_SELECT,
		I_BUS_MATCHING_SELECT, I_BYTE_ORDER_SELECT, I_RETRANSMIT_OPTION,
		I_FLAG_TIMING_SELECT, I_INTERSPERSED_PARITY, I_ASYNC_WRITE_SELECT,
		I_ASYNC_READ_SELECT, I_SERIAL_LOAD_SELECT};
	assign {wclk_f, wen_n_f, din_f, rclk_f, ren_n_f, rcs_n_f, tri_n_f, mark_f, rt_n_f,
		fsi_f, sclk_f, sen_n_f, ld_n_f, mrs_f, prs_f, static_f, async_write_select_f, async_read_select_f,
		serial_f} = pin_f_q;

	// Three-stage pin sampling; a level only counts once stages two and three agree
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	for (genvar i = 0; i < NP; i++)
	begin : g_filt
		always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
		begin
			if (!I_RST_N)
				pin_f_q[i] <= 1'b0;
			else if (s2_q[i] == s3_q[i])
				pin_f_q[i] <= s3_q[i];
		end
	end

	// Raw reset pins act at once on pointers and flags, not after sampling
	assign ptr_rst_n = I_RST_N & I_MASTER_RESET_N & I_PARTIAL_RESET_N;
	assign mst_rst_n = I_RST_N & I_MASTER_RESET_N;

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			wclk_d_q <= 1'b0;
			rclk_d_q <= 1'b0;
			sclk_d_q <= 1'b0;
		end
		else
		begin
			wclk_d_q <= wclk_f;
			rclk_d_q <= rclk_f;
			sclk_d_q <= sclk_f;
		end
	end

	assign w_edge = wclk_f & ~wclk_d_q;
	assign r_edge = rclk_f & ~rclk_d_q;
	assign s_edge = sclk_f & ~sclk_d_q;

	// Configuration follows the pins for as long as master reset is held
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			fwft_q     <= 1'b0;
			async_wr_q <= 1'b0;
			async_rd_q <= 1'b0;
			serial_q   <= 1'b0;
			static_q   <= CFG_RST;
		end
		else if (!mrs_f)
		begin
			fwft_q     <= fsi_f;
			async_wr_q <= ~async_write_select_f;
			async_rd_q <= ~async_read_select_f;
			serial_q   <= serial_f;
			static_q   <= static_f;
		end
	end

	assign count     = wr_ptr_q - rd_ptr_q;
	assign mark_span = wr_ptr_q - mark_ptr_q;
	assign mark_block = mark_q & (mark_span == DEPTH_V);
	assign full_eff  = (count == DEPTH_V) | mark_block;
	// Strobe mode ignores the enable pin; the writer keeps it low anyway
	assign wr_do = w_edge & (async_wr_q | ~wen_n_f) & ~full_eff & mrs_f & prs_f;

	always_ff @(posedge I_CORE_CLK or negedge ptr_rst_n)
	begin
		if (!ptr_rst_n)
			wr_ptr_q <= '0;
		else if (wr_do)
			wr_ptr_q <= wr_ptr_q + 1'b1;
	end

	// Storage has no reset; it is large and never read before being written
	always_ff @(posedge I_CORE_CLK)
	begin
		if (wr_do)
			mem[wr_ptr_q[AW-1:0]] <= din_f;
	end

	assign rt_req    = r_edge & mark_q & ~rt_n_f;
	assign rd_do     = r_edge & ~fwft_q & (async_rd_q | (~ren_n_f & ~rcs_n_f))
		& (count != '0) & ~rt_hold_q & ~rt_req;
	assign fw_rd     = r_edge & fwft_q & ~ren_n_f & ~rcs_n_f & ~rt_hold_q & ~rt_req;
	assign fall_load = r_edge & fwft_q & ~out_valid_q & (count != '0) & ~rt_hold_q
		& ~rt_req & (fall_cnt_q == 2'(FALL_EDGES - 1));
	assign rt_load   = r_edge & fwft_q & rt_hold_q & rt_n_f & (count != '0);
	assign pop       = rd_do | fall_load | rt_load | (fw_rd & out_valid_q & (count != '0));

	always_ff @(posedge I_CORE_CLK or negedge ptr_rst_n)
	begin
		if (!ptr_rst_n)
		begin
			rd_ptr_q    <= '0;
			O_DATA_OUT  <= '0;
			out_valid_q <= 1'b0;
			fall_cnt_q  <= 2'h0;
		end
		else if (rt_req)
		begin
			rd_ptr_q    <= mark_ptr_q;
			out_valid_q <= 1'b0;
			fall_cnt_q  <= 2'h0;
		end
		else if (pop)
		begin
			O_DATA_OUT  <= mem[rd_ptr_q[AW-1:0]];
			rd_ptr_q    <= rd_ptr_q + 1'b1;
			out_valid_q <= 1'b1;
			fall_cnt_q  <= 2'h0;
		end
		else if (fw_rd & out_valid_q)
			out_valid_q <= 1'b0;
		else if (r_edge & fwft_q & ~out_valid_q & (count != '0) & ~rt_hold_q)
			fall_cnt_q  <= fall_cnt_q + 2'h1;
	end

	// Mark is taken on entry only; later edges with mark high keep the same location
	always_ff @(posedge I_CORE_CLK or negedge ptr_rst_n)
	begin
		if (!ptr_rst_n)
		begin
			mark_q     <= 1'b0;
			mark_ptr_q <= '0;
		end
		else if (r_edge)
		begin
			if (!mark_f)
				mark_q <= 1'b0;
			else if (!mark_q && (fwft_q ? out_valid_q : O_EMPTY_FLAG_N))
			begin
				mark_q     <= 1'b1;
				mark_ptr_q <= rd_ptr_q - 1'b1;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge ptr_rst_n)
	begin
		if (!ptr_rst_n)
			rt_hold_q <= 1'b0;
		else if (rt_req)
			rt_hold_q <= 1'b1;
		else if (r_edge & rt_n_f)
			rt_hold_q <= 1'b0;
	end

	// Flags follow both ports every core cycle, which also covers strobe modes
	assign af_sum = {1'b0, count} + {2'b00, af_off_q};

	always_ff @(posedge I_CORE_CLK or negedge ptr_rst_n)
	begin
		if (!ptr_rst_n)
		begin
			O_EMPTY_FLAG_N        <= 1'b0;
			O_OUTPUT_READY_N      <= 1'b1;
			O_FULL_FLAG_N         <= 1'b1;
			O_INPUT_READY_N       <= 1'b0;
			O_ALMOST_EMPTY_FLAG_N <= 1'b0;
			O_ALMOST_FULL_FLAG_N  <= 1'b1;
			O_HALF_FULL_FLAG_N    <= 1'b1;
		end
		else
		begin
			O_EMPTY_FLAG_N        <= (count != '0) & ~rt_hold_q;
			O_OUTPUT_READY_N      <= ~out_valid_q;
			O_FULL_FLAG_N         <= ~full_eff;
			O_INPUT_READY_N       <= full_eff;
			O_ALMOST_EMPTY_FLAG_N <= count > {1'b0, ae_off_q};
			O_ALMOST_FULL_FLAG_N  <= af_sum < {1'b0, DEPTH_V};
			O_HALF_FULL_FLAG_N    <= count <= HALF_V;
		end
	end

	// Offsets survive partial reset; only master reset or I_RST_N restores defaults
	always_ff @(posedge I_CORE_CLK or negedge mst_rst_n)
	begin
		if (!mst_rst_n)
		begin
			ae_off_q <= AW'(AE_OFFSET_RST);
			af_off_q <= AW'(AF_OFFSET_RST);
		end
		else if (serial_q & mrs_f & s_edge & ~sen_n_f & ~ld_n_f)
			{ae_off_q, af_off_q} <= {ae_off_q[AW-2:0], af_off_q, fsi_f};
	end

	// Read select is sampled on read edges in synchronous read mode only; during master or partial reset only tristate pin counts
	always_ff @(posedge I_CORE_CLK or negedge ptr_rst_n)
	begin
		if (!ptr_rst_n)
			rcs_drive_q <= 1'b1;
		else if (r_edge & ~async_rd_q)
			rcs_drive_q <= ~rcs_n_f;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			O_DATA_OUT_OE   <= 1'b0;
			O_STATIC_CONFIG <= CFG_RST;
		end
		else
		begin
			O_DATA_OUT_OE   <= ~tri_n_f & (~(mrs_f & prs_f) | async_rd_q | rcs_drive_q);
			O_STATIC_CONFIG <= static_q;
		end
	end

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!ptr_rst_n);

	property p_reset_flags;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!ptr_rst_n |-> (!O_ALMOST_EMPTY_FLAG_N && O_ALMOST_FULL_FLAG_N && O_HALF_FULL_FLAG_N
			&& !O_EMPTY_FLAG_N && O_OUTPUT_READY_N && wr_ptr_q == '0 && rd_ptr_q == '0);
	endproperty
	a_reset_flags: assert property (p_reset_flags)
		else $error("reset did not home pointers and flags");

	property p_out_clear;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!ptr_rst_n |-> (O_DATA_OUT == '0);
	endproperty
	a_out_clear: assert property (p_out_clear)
		else $error("output register not cleared by reset");

	property p_mode_capture;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!mrs_f |=> (fwft_q == $past(fsi_f) && async_rd_q == !$past(async_read_select_f));
	endproperty
	a_mode_capture: assert property (p_mode_capture)
		else $error("mode not taken from pins during master reset");

	property p_mark_block;
		mark_q && mark_span == DEPTH_V |=> $stable(wr_ptr_q);
	endproperty
	a_mark_block: assert property (p_mark_block)
		else $error("write pointer passed the mark");

	property p_retx_ptr;
		r_edge && mark_q && !rt_n_f |=> rd_ptr_q == $past(mark_ptr_q) && rt_hold_q;
	endproperty
	a_retx_ptr: assert property (p_retx_ptr)
		else $error("retransmit did not restore the read pointer");

	property p_ef_rt;
		rt_hold_q && !fwft_q |=> !O_EMPTY_FLAG_N;
	endproperty
	a_ef_rt: assert property (p_ef_rt)
		else $error("empty flag high during retransmit");

	property p_or_rt;
		rt_hold_q && fwft_q |=> ##1 (O_OUTPUT_READY_N || !rt_hold_q);
	endproperty
	a_or_rt: assert property (p_or_rt)
		else $error("output ready asserted during retransmit");

	property p_std_read;
		!fwft_q && !async_rd_q && r_edge && ren_n_f && !(mark_q && !rt_n_f)
			|=> $stable(rd_ptr_q);
	endproperty
	a_std_read: assert property (p_std_read)
		else $error("read without enable in standard mode");

	property p_mark_exit;
		r_edge && !mark_f |=> !mark_q;
	endproperty
	a_mark_exit: assert property (p_mark_exit)
		else $error("retransmit mode kept with mark low");
endmodule

// ==== hdl/frm_pkg.sv ====
// Constants shared by the FIFO reset, mode and retransmit control logic.
// Assumes a single core clock; all pin timing except reset assertion is oversampled by it.
package frm_pkg;
	localparam int DATA_W        = 36;
	localparam int ADDR_W        = 16;
	localparam int SYNC_STAGES   = 3;
	localparam int FALL_EDGES    = 3;
	localparam int CFG_W         = 7;
	localparam int AE_OFFSET_RST = 127;
	localparam int AF_OFFSET_RST = 127;
	localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
endpackage

// ==== testbench/frm_port_model.sv ====
// Writer and reader model driving the write and read pin groups of the FIFO.
// Assumes a core clock for alignment; pin clocks idle low between transfers.
`timescale 1ns/1ns
module frm_port_model
(
	// Alignment clock
	input  wire logic        clk,
	// Write pins
	output logic             write_clk,
	output logic             write_enable_n,
	output logic [35:0]      data_in,
	// Read pins
	output logic             read_clk,
	output logic             read_enable_n,
	output logic             mark,
	output logic             retransmit_n
);
	initial
	begin
		write_clk = 1'b0;
		write_enable_n = 1'b1;
		data_in = 36'h0;
		read_clk = 1'b0;
		read_enable_n = 1'b1;
		mark = 1'b0;
		retransmit_n = 1'b1;
	end

	// One word every 190 ns, 62 ns setup and 63 ns hold; data goes to its inverse once its hold is over
	task automatic wr(input logic [35:0] d, input logic en_n);
		@(posedge clk);
		data_in <= d;
		write_enable_n <= en_n;
		#62 write_clk <= 1'b1;
		#63 write_clk <= 1'b0;
		data_in <= ~d;
		repeat (6) @(posedge clk);
	endtask

	// Mark and retransmit levels are kept after the edge, as retransmit mode needs
	task automatic rd(input logic en_n, input logic mk, input logic rt_n);
		@(posedge clk);
		read_enable_n <= en_n;
		mark <= mk;
		retransmit_n <= rt_n;
		#62 read_clk <= 1'b1;
		#63 read_clk <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
endmodule

// ==== testbench/test_frm_fifo_ctrl.sv ====
// Self-checking bench for the FIFO reset, mode and retransmit control.
// Assumes the pin model above; memory depth shrunk to 16 words.
`timescale 1ns/1ns
module test_frm_fifo_ctrl;
	import frm_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        mrs_n = 1'b1;
	logic        prs_n = 1'b1;
	logic        fw = 1'b0;
	logic        ayw = 1'b1;
	logic        ayr = 1'b1;
	logic [6:0]  cfg = 7'h00;
	logic        rsel_n = 1'b0;
	logic        tri_n = 1'b0;
	logic        sclk = 1'b0;
	logic        sen_n = 1'b1;
	logic        ld_n = 1'b1;
	logic        ssel = 1'b0;
	logic        wclk, wen_n, rclk, ren_n, mk, rt_n, oe;
	logic        ef_n, or_n, ff_n, ir_n, ae_n, af_n, hf_n;
	logic [35:0] din, dout;
	logic [6:0]  scfg;
	logic [6:0]  fl;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;

	assign fl = {ef_n, or_n, ff_n, ir_n, ae_n, af_n, hf_n};
	always #5 clk = ~clk;

	frm_port_model i_frm_port_model (.clk(clk), .write_clk(wclk), .write_enable_n(wen_n),
		.data_in(din), .read_clk(rclk), .read_enable_n(ren_n), .mark(mk), .retransmit_n(rt_n));

	frm_fifo_ctrl #(.AW(4)) i_frm_fifo_ctrl (.I_CORE_CLK(clk), .I_RST_N(rst_n),
		.I_MASTER_RESET_N(mrs_n), .I_PARTIAL_RESET_N(prs_n), .I_WRITE_CLK(wclk),
		.I_WRITE_ENABLE_N(wen_n), .I_DATA_IN(din), .I_READ_CLK(rclk), .I_READ_ENABLE_N(ren_n),
		.I_READ_SELECT_N(rsel_n), .I_OUTPUT_TRISTATE_N(tri_n), .I_MARK(mk),
		.I_RETRANSMIT_N(rt_n), .I_FALLTHROUGH_SERIAL_IN(fw), .I_SERIAL_CLK(sclk),
		.I_SERIAL_ENABLE_N(sen_n), .I_LOAD_N(ld_n), .I_OUTPUT_WIDTH_SELECT(cfg[6]),
		.I_INPUT_WIDTH_SELECT(cfg[5]), .I_BUS_MATCHING_SELECT(cfg[4]),
		.I_BYTE_ORDER_SELECT(cfg[3]), .I_RETRANSMIT_OPTION(cfg[2]),
		.I_FLAG_TIMING_SELECT(cfg[1]), .I_INTERSPERSED_PARITY(cfg[0]),
		.I_ASYNC_WRITE_SELECT(ayw), .I_ASYNC_READ_SELECT(ayr), .I_SERIAL_LOAD_SELECT(ssel),
		.O_DATA_OUT(dout), .O_DATA_OUT_OE(oe), .O_EMPTY_FLAG_N(ef_n), .O_OUTPUT_READY_N(or_n),
		.O_FULL_FLAG_N(ff_n), .O_INPUT_READY_N(ir_n), .O_ALMOST_EMPTY_FLAG_N(ae_n),
		.O_ALMOST_FULL_FLAG_N(af_n), .O_HALF_FULL_FLAG_N(hf_n), .O_STATIC_CONFIG(scfg));

	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// m selects master or partial reset; mode pins change too, partial must ignore them
	task automatic pin_reset(input logic m, input logic f, input logic aw, input logic ar,
		input logic [6:0] c, input logic [6:0] ec);
		@(posedge clk);
		mrs_n <= ~m;
		prs_n <= m;
		fw <= f;
		ayw <= aw;
		ayr <= ar;
		cfg <= c;
		#2 chk(dout, 36'h0);
		repeat (12) @(posedge clk);
		chk(36'(fl), 36'h33);
		mrs_n <= 1'b1;
		prs_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(36'(scfg), 36'(ec));
	endtask

	task automatic rd3();
		repeat (3) i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
	endtask

	// Offset bits go MSB first, almost-empty offset ahead of almost-full; eight bits for AW=4
	task automatic ser_load(input logic [7:0] bits);
		sen_n <= 1'b0;
		ld_n <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			fw <= bits[i];
			repeat (6) @(posedge clk);
			sclk <= 1'b1;
			repeat (6) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (6) @(posedge clk);
		sen_n <= 1'b1;
		ld_n <= 1'b1;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			close_out();
		end
	end

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		// Standard mode, synchronous ports
		pin_reset(1'b1, 1'b0, 1'b1, 1'b1, 7'h55, 7'h55);
		for (int i = 0; i < 3; i++)
			i_frm_port_model.wr(36'ha0 + 36'(i), 1'b0);
		chk(36'(ef_n), 36'h1);
		i_frm_port_model.rd(1'b0, 1'b0, 1'b1);
		chk(dout, 36'ha0);
		i_frm_port_model.rd(1'b1, 1'b1, 1'b1);
		i_frm_port_model.rd(1'b0, 1'b1, 1'b1);
		chk(dout, 36'ha1);
		i_frm_port_model.rd(1'b1, 1'b1, 1'b0);
		i_frm_port_model.rd(1'b1, 1'b1, 1'b0);
		chk(36'(ef_n), 36'h0);
		i_frm_port_model.rd(1'b1, 1'b1, 1'b1);
		chk(36'(ef_n), 36'h1);
		i_frm_port_model.rd(1'b0, 1'b1, 1'b1);
		chk(dout, 36'ha0);
		// Thirteen writes reach the mark; the fourteenth must be held off
		for (int i = 0; i < 14; i++)
			i_frm_port_model.wr(36'hf0 + 36'(i), 1'b0);
		chk(36'(ff_n), 36'h0);
		i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
		i_frm_port_model.rd(1'b0, 1'b0, 1'b1);
		chk(dout, 36'ha1);
		chk(36'(ff_n), 36'h1);
		// Partial reset with the mode pin flipped: standard mode must stay
		pin_reset(1'b0, 1'b1, 1'b1, 1'b1, 7'h2a, 7'h55);
		i_frm_port_model.wr(36'he0, 1'b0);
		rd3();
		chk(dout, 36'h0);
		i_frm_port_model.rd(1'b0, 1'b0, 1'b1);
		chk(dout, 36'he0);
		rsel_n <= 1'b1;
		i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
		chk(36'(oe), 36'h0);
		rsel_n <= 1'b0;
		i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
		chk(36'(oe), 36'h1);
		// Fall-through mode
		pin_reset(1'b1, 1'b1, 1'b1, 1'b1, 7'h2a, 7'h2a);
		i_frm_port_model.wr(36'hb0, 1'b0);
		i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
		i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
		chk(dout, 36'h0);
		i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
		chk(dout, 36'hb0);
		chk(36'(or_n), 36'h0);
		i_frm_port_model.wr(36'hb1, 1'b0);
		i_frm_port_model.wr(36'hb2, 1'b0);
		i_frm_port_model.rd(1'b0, 1'b0, 1'b1);
		chk(dout, 36'hb1);
		i_frm_port_model.rd(1'b1, 1'b1, 1'b1);
		i_frm_port_model.rd(1'b0, 1'b1, 1'b1);
		chk(dout, 36'hb2);
		i_frm_port_model.rd(1'b1, 1'b1, 1'b0);
		chk(36'(or_n), 36'h1);
		i_frm_port_model.rd(1'b1, 1'b1, 1'b1);
		chk(dout, 36'hb1);
		chk(36'(or_n), 36'h0);
		i_frm_port_model.rd(1'b1, 1'b0, 1'b1);
		pin_reset(1'b0, 1'b0, 1'b1, 1'b1, 7'h55, 7'h2a);
		i_frm_port_model.wr(36'hc0, 1'b0);
		rd3();
		chk(dout, 36'hc0);
		// Strobe write and strobe read, standard mode only; offsets of one loaded serially
		ssel <= 1'b1;
		pin_reset(1'b1, 1'b0, 1'b0, 1'b0, 7'h7f, 7'h7f);
		ser_load(8'h11);
		i_frm_port_model.wr(36'hd0, 1'b0);
		i_frm_port_model.wr(36'hd1, 1'b0);
		chk(36'(ae_n), 36'h1);
		i_frm_port_model.rd(1'b0, 1'b0, 1'b1);
		chk(dout, 36'hd0);
		chk(36'(af_n), 36'h1);
		for (int i = 0; i < 15; i++)
			i_frm_port_model.wr(36'h100 + 36'(i), 1'b0);
		chk(36'(ff_n), 36'h0);
		i_frm_port_model.rd(1'b0, 1'b0, 1'b1);
		chk(dout, 36'hd1);
		chk(36'(ff_n), 36'h1);
		tri_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(36'(oe), 36'h0);
		tri_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(36'(oe), 36'h1);
		close_out();
	end
endmodule
